// File: inc/eal_pkg.sv
// Purpose: Shared constants and types for the event alert logic.
// Assumes: Registers are 8 bits wide and addressed by an 8-bit register index.
// Notes:   Alert timing is derived from the system clock rate.
package eal_pkg;

   // Register offsets
   localparam logic [7:0] ADDR_ALERT_CONFIG = 8'h32;
   localparam logic [7:0] ADDR_EVENT_MASK = 8'h33;
   localparam logic [7:0] ADDR_EVENT_LATCH = 8'h36;

   // Values after reset
   localparam logic [7:0] ALERT_CONFIG_RESET = 8'h00;
   localparam logic [7:0] EVENT_MASK_RESET = 8'hFF;
   localparam logic [7:0] EVENT_LATCH_RESET = 8'h00;
   localparam logic [7:0] RDATA_RESET = 8'h00;

   // Configuration field positions
   localparam int CFG_POL_BIT = 7;
   localparam int CFG_STYLE_LSB = 5;
   localparam int CFG_VIEW_BIT = 2;
   // Writable configuration bits; the rest are reserved and read as zero
   localparam logic [7:0] CFG_WRITE_MASK = 8'hE4;

   // Event bit positions in the mask and latch registers
   localparam int EVT_CLK_ERR_BIT = 7;
   localparam int EVT_PLL_LOCK_BIT = 6;
   localparam int EVT_MIX_SAT_BIT = 5;
   localparam int EVT_VAD_UP_BIT = 4;
   localparam int EVT_VAD_DOWN_BIT = 3;
   // Latch bits that hold an event; bits 2..0 always read zero
   localparam logic [7:0] LATCH_IMPL_MASK = 8'hF8;

   // Alert style codes
   localparam logic [1:0] STYLE_LEVEL = 2'h0;
   localparam logic [1:0] STYLE_RESERVED = 2'h1;
   localparam logic [1:0] STYLE_REPEAT = 2'h2;
   localparam logic [1:0] STYLE_ONCE = 2'h3;

   // Alert timing
   localparam int CLK_FREQ_HZ = 50_000_000;
   localparam int ALERT_ON_TIME_US = 2000;
   localparam int ALERT_PERIOD_US = 4000;
   localparam int ALERT_ON_CYC = (CLK_FREQ_HZ / 1_000_000) * ALERT_ON_TIME_US;
   localparam int ALERT_PERIOD_CYC = (CLK_FREQ_HZ / 1_000_000) * ALERT_PERIOD_US;

   // Timer states
   typedef enum logic {
      TMR_IDLE,
      TMR_RUN
   } eal_tmr_state_t;

endpackage : eal_pkg

// File: inc/eal_timer_if.sv
// Purpose: Carries the control and status of the alert pulse timer.
// Assumes: Both ends run on the same clock.
// Notes:   ctrl is the alert logic end, timer is the counter end.
`timescale 1ns/1ps
interface eal_timer_if;
   logic restart;  // Start or retrigger the pulse window
   logic periodic; // Repeat every period instead of one shot
   logic hold;     // Keep repeating while high
   logic on;       // Inside the asserted part of the window
   logic busy;     // Timer is counting

   modport ctrl (
      output restart,
      output periodic,
      output hold,
      input on,
      input busy
   );

   modport timer (
      input restart,
      input periodic,
      input hold,
      output on,
      output busy
   );
endinterface : eal_timer_if

// File: verilog/eal_alert_timer.sv
// Purpose: Pulse window timer for the repeating and one-shot alert styles.
// Assumes: ON_CYC is below PERIOD_CYC and both are at least 1.
// Notes:   The on flag is registered so it lines up with the counter state.
`timescale 1ns/1ps
module eal_alert_timer
   import eal_pkg::*;
#(
   parameter int ON_CYC = ALERT_ON_CYC,
   parameter int PERIOD_CYC = ALERT_PERIOD_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   eal_timer_if.timer tmr
);

   localparam int CNT_W = $clog2(PERIOD_CYC + 1);
   localparam logic [CNT_W-1:0] ON_CNT = CNT_W'(ON_CYC);
   localparam logic [CNT_W-1:0] ON_LAST = CNT_W'(ON_CYC - 1);
   localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(PERIOD_CYC - 1);

   typedef struct packed {
      eal_tmr_state_t mode;
      logic [CNT_W-1:0] cnt;
      logic on;
   } eal_tmr_t;

   localparam eal_tmr_t TMR_RESET = '{mode: TMR_IDLE, cnt: '0, on: 1'b0};

   eal_tmr_t t_reg;
   eal_tmr_t t_next;

   // Window counter; a one-shot retrigger restarts the full on time
   always_comb begin
      t_next = t_reg;
      case (t_reg.mode)
         TMR_IDLE: begin
            if (tmr.restart) begin
               t_next.mode = TMR_RUN;
               t_next.cnt = '0;
            end
         end
         TMR_RUN: begin
            if (tmr.restart && !tmr.periodic) begin
               t_next.cnt = '0;
            end else if (tmr.periodic && !tmr.hold) begin
               t_next.mode = TMR_IDLE; // Nothing pending: stop at once
               t_next.cnt = '0;
            end else if (!tmr.periodic && t_reg.cnt >= ON_LAST) begin
               // A switch from the repeat style in its off phase must not run a late pulse
               t_next.mode = TMR_IDLE;
               t_next.cnt = '0;
            end else if (t_reg.cnt == PERIOD_LAST) begin
               t_next.cnt = '0;
            end else begin
               t_next.cnt = t_reg.cnt + CNT_W'(1);
            end
         end
         default: begin
            t_next = TMR_RESET;
         end
      endcase
      t_next.on = (t_next.mode == TMR_RUN) && (t_next.cnt < ON_CNT);
   end

   // State register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         t_reg <= TMR_RESET;
      end else begin
         t_reg <= t_next;
      end
   end

   assign tmr.on = t_reg.on;
   assign tmr.busy = (t_reg.mode == TMR_RUN);

endmodule : eal_alert_timer

// File: verilog/eal_event_alert.sv
// Purpose: Latches internal events, masks them and drives the alert pin.
// Assumes: Event inputs come from logic on clk_i; the register port is the
//          control interface's internal register access, one access per cycle.
// Notes:   Reads return data one cycle after the read strobe.
//
// Functional notes
// - Polarity bit 7 selects alert pin active low (0) or active high (1).
// - Style 0 holds alert while any unmasked latched event exists; 1 reserved.
// - Style 2 asserts alert 2 ms in every 4 ms while events pending.
// - Style 3 gives a 2 ms alert pulse per unmasked event; an event during a pulse restarts its 2 ms.
// - View bit 2 clear shows all latched events; set shows only unmasked ones.
// - Mask resets to all ones; one masks an event, zero passes it.
// - Mask bit 7 is clock error, mask bit 6 is PLL lock.
// - Mask bit 4 is detector power up, mask bit 3 detector power down.
// - Latch bit 7 records serial port clock error, resets zero, self clears.
// - Latch bit 6 records PLL lock, resets zero, self clears.
// - Latch bit 5 records input mixing saturation, self clears.
// - Latch bit 4 records detector power up, self clears.
// - Latch bit 3 records detector power down, self clears.
`timescale 1ns/1ps
module eal_event_alert
   import eal_pkg::*;
#(
   parameter int ON_CYC = ALERT_ON_CYC,
   parameter int PERIOD_CYC = ALERT_PERIOD_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // Register access
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // Event sources, high for each cycle the event is present
   input wire logic evt_audio_serial_port_clk_err_i,
   input wire logic evt_pll_lock_i,
   input wire logic evt_mix_sat_i,
   input wire logic evt_voice_activity_detector_up_i,
   input wire logic evt_voice_activity_detector_down_i,
   // Alert pin
   output logic alert_pin_o
);

   typedef struct packed {
      logic [7:0] cfg;
      logic [7:0] mask;
      logic [7:0] latch;
      logic [7:0] rdata;
      logic rvalid;
      logic pin;
   } eal_state_t;

   localparam eal_state_t ST_RESET = '{
      cfg: ALERT_CONFIG_RESET,
      mask: EVENT_MASK_RESET,
      latch: EVENT_LATCH_RESET,
      rdata: RDATA_RESET,
      rvalid: 1'b0,
      pin: 1'b1
   };

   // Unmasked part of an event vector; a mask bit of one blocks the event
   function automatic logic [7:0] eal_unmasked(input logic [7:0] ev, input logic [7:0] msk);
      eal_unmasked = ev & ~msk & LATCH_IMPL_MASK;
   endfunction : eal_unmasked

   // Pin level for an internal alert state under the chosen polarity
   function automatic logic eal_pin_level(input logic active, input logic pol_high);
      eal_pin_level = pol_high ? active : ~active;
   endfunction : eal_pin_level

   eal_state_t st_reg;
   eal_state_t st_next;

   eal_timer_if tmr_bus ();

   logic [7:0] evt_vec;
   logic [7:0] pending_vec;
   logic [7:0] new_unmasked;
   logic [7:0] latch_view;
   logic [1:0] style;
   logic pol_high;
   logic view_filter;
   logic pending;
   logic new_evt;
   logic rd_latch;
   logic alert_active;

   // Gather event sources at their latch and mask bit positions
   always_comb begin
      evt_vec = 8'h00;
      evt_vec[EVT_CLK_ERR_BIT] = evt_audio_serial_port_clk_err_i;
      evt_vec[EVT_PLL_LOCK_BIT] = evt_pll_lock_i;
      evt_vec[EVT_MIX_SAT_BIT] = evt_mix_sat_i;
      evt_vec[EVT_VAD_UP_BIT] = evt_voice_activity_detector_up_i;
      evt_vec[EVT_VAD_DOWN_BIT] = evt_voice_activity_detector_down_i;
   end

   // Configuration fields
   assign pol_high = st_reg.cfg[CFG_POL_BIT];
   assign style = st_reg.cfg[CFG_STYLE_LSB +: 2];
   assign view_filter = st_reg.cfg[CFG_VIEW_BIT];

   // Pending state comes from the latch; new occurrences straight from the sources
   assign pending_vec = eal_unmasked(st_reg.latch, st_reg.mask);
   assign pending = |pending_vec;
   assign new_unmasked = eal_unmasked(evt_vec, st_reg.mask);
   assign new_evt = |new_unmasked;

   // Latch readback, filtered by the view bit
   assign latch_view = view_filter ? pending_vec : (st_reg.latch & LATCH_IMPL_MASK);
   assign rd_latch = reg_rd_i && (reg_addr_i == ADDR_EVENT_LATCH);

   // Timer control: repeat style runs while pending, one-shot style fires per event
   assign tmr_bus.periodic = (style == STYLE_REPEAT);
   assign tmr_bus.hold = pending;
   always_comb begin
      tmr_bus.restart = 1'b0;
      if (style == STYLE_REPEAT) begin
         tmr_bus.restart = pending && !tmr_bus.busy;
      end else if (style == STYLE_ONCE) begin
         tmr_bus.restart = new_evt;
      end
   end

   eal_alert_timer #(
      .ON_CYC(ON_CYC),
      .PERIOD_CYC(PERIOD_CYC)
   ) u_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tmr(tmr_bus)
   );

   // Internal alert state for each style; the reserved code keeps the pin idle
   // rather than guessing a behaviour software must not rely on
   always_comb begin
      case (style)
         STYLE_LEVEL: begin
            alert_active = pending;
         end
         STYLE_REPEAT: begin
            alert_active = pending && tmr_bus.on;
         end
         STYLE_ONCE: begin
            alert_active = tmr_bus.on;
         end
         default: begin
            alert_active = 1'b0;
         end
      endcase
   end

   // Next state of registers, readback and pin
   always_comb begin
      st_next = st_reg;
      st_next.rvalid = reg_rd_i;
      // Register writes; the latch is read-only and ignores writes
      if (reg_wr_i) begin
         if (reg_addr_i == ADDR_ALERT_CONFIG) begin
            st_next.cfg = reg_wdata_i & CFG_WRITE_MASK;
         end else if (reg_addr_i == ADDR_EVENT_MASK) begin
            st_next.mask = reg_wdata_i;
         end
      end
      // Readback; unmapped offsets return zero
      if (reg_rd_i) begin
         if (reg_addr_i == ADDR_ALERT_CONFIG) begin
            st_next.rdata = st_reg.cfg;
         end else if (reg_addr_i == ADDR_EVENT_MASK) begin
            st_next.rdata = st_reg.mask;
         end else if (reg_addr_i == ADDR_EVENT_LATCH) begin
            st_next.rdata = latch_view;
         end else begin
            st_next.rdata = 8'h00;
         end
      end
      // Clear only what the read showed, then set: an event in the read cycle survives
      st_next.latch = st_reg.latch & ~(rd_latch ? latch_view : 8'h00);
      st_next.latch = (st_next.latch | evt_vec) & LATCH_IMPL_MASK;
      // Registered pin so it never glitches on style or polarity changes
      st_next.pin = eal_pin_level(alert_active, pol_high);
   end

   // State register; reset leaves the pin high, the inactive level for polarity 0
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_reg <= ST_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from flip-flops
   assign reg_rdata_o = st_reg.rdata;
   assign reg_rvalid_o = st_reg.rvalid;
   assign alert_pin_o = st_reg.pin;

endmodule : eal_event_alert

// File: testbench/eal_event_alert_asserts.sv
// Purpose: Port-level assertions for the event alert block.
// Assumes: The host never writes the reserved style code.
// Notes:   Shadow copies of config and mask follow host writes.
`timescale 1ns/1ps
module eal_event_alert_asserts
   import eal_pkg::*;
#(
   parameter int ON_CYC = ALERT_ON_CYC,
   parameter int PERIOD_CYC = ALERT_PERIOD_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic reg_rvalid_o,
   input wire logic evt_audio_serial_port_clk_err_i,
   input wire logic evt_pll_lock_i,
   input wire logic evt_mix_sat_i,
   input wire logic evt_voice_activity_detector_up_i,
   input wire logic evt_voice_activity_detector_down_i,
   input wire logic alert_pin_o
);
   logic [7:0] cfg_reg;
   logic [7:0] msk_reg;
   logic rd_lt;
   logic no_evt;
   // Shadows let read data be judged without seeing inside
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_reg <= ALERT_CONFIG_RESET;
         msk_reg <= EVENT_MASK_RESET;
      end else if (reg_wr_i) begin
         if (reg_addr_i == ADDR_ALERT_CONFIG) cfg_reg <= reg_wdata_i & CFG_WRITE_MASK;
         if (reg_addr_i == ADDR_EVENT_MASK) msk_reg <= reg_wdata_i;
      end
   end
   // Decoded helpers
   assign rd_lt = reg_rd_i && reg_addr_i == ADDR_EVENT_LATCH;
   assign no_evt = !(evt_audio_serial_port_clk_err_i || evt_pll_lock_i || evt_mix_sat_i
      || evt_voice_activity_detector_up_i || evt_voice_activity_detector_down_i);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_CFG_READ: assert property (reg_rd_i && reg_addr_i == ADDR_ALERT_CONFIG |=> reg_rvalid_o
      && reg_rdata_o == $past(cfg_reg)) else $error("config read data wrong");
   AST_MASK_READ: assert property (reg_rd_i && reg_addr_i == ADDR_EVENT_MASK |=> reg_rvalid_o
      && reg_rdata_o == $past(msk_reg)) else $error("mask read data wrong");
   AST_LATCH_VIEW: assert property (rd_lt && cfg_reg[2] |=> (reg_rdata_o & $past(msk_reg)) == 8'h00)
      else $error("masked event visible in filtered view");
   AST_LATCH_LOW: assert property (rd_lt |=> reg_rdata_o[2:0] == 3'h0)
      else $error("unused latch bits set");
   AST_CLK_ERR_SET: assert property (evt_audio_serial_port_clk_err_i && !cfg_reg[2] ##1 !reg_rd_i
      ##1 rd_lt |=> reg_rdata_o[7]) else $error("clock error not latched");
   AST_PLL_SET: assert property (evt_pll_lock_i && !cfg_reg[2] ##1 !reg_rd_i ##1 rd_lt
      |=> reg_rdata_o[6]) else $error("lock event not latched");
   AST_SELF_CLEAR: assert property (rd_lt && !cfg_reg[2] && no_evt ##1 no_evt ##1 rd_lt && no_evt
      |=> reg_rdata_o == 8'h00) else $error("latch not cleared by read");
   AST_MASKED_IDLE: assert property (msk_reg == 8'hFF && $past(msk_reg) == 8'hFF
      && cfg_reg == $past(cfg_reg) |-> alert_pin_o == !cfg_reg[7]) else $error("pin active while masked");
   AST_LEVEL_HOLD: assert property (evt_audio_serial_port_clk_err_i && !msk_reg[7]
      && cfg_reg[6:5] == STYLE_LEVEL |=> ##1 alert_pin_o == cfg_reg[7]) else $error("level alert missing");
   // Main scenarios reached
   cover property (cfg_reg[6:5] == STYLE_ONCE && $fell(alert_pin_o));
   cover property (cfg_reg[6:5] == STYLE_REPEAT && $rose(alert_pin_o));
   cover property (rd_lt && cfg_reg[2]);
endmodule : eal_event_alert_asserts

bind eal_event_alert eal_event_alert_asserts #(.ON_CYC(ON_CYC), .PERIOD_CYC(PERIOD_CYC)) chk_u (
   .clk_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o,
   .evt_audio_serial_port_clk_err_i, .evt_pll_lock_i, .evt_mix_sat_i,
   .evt_voice_activity_detector_up_i, .evt_voice_activity_detector_down_i, .alert_pin_o);

// File: testbench/eal_host_model.sv
// Purpose: Host processor model driving the register port.
// Assumes: Only config and mask are ever written.
// Notes:   Read data is taken when the valid pulse shows.
`timescale 1ns/1ps
module eal_host_model
   import eal_pkg::*;
(
   input wire logic clk_i,
   output logic [7:0] reg_addr_o,
   output logic reg_wr_o,
   output logic [7:0] reg_wdata_o,
   output logic reg_rd_o,
   input wire logic [7:0] reg_rdata_i,
   input wire logic reg_rvalid_i
);
   // Idle bus from time zero
   initial begin
      reg_addr_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_wdata_o = 8'h00;
      reg_rd_o = 1'b0;
   end
   // Reserved bits always carry their reset value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_o <= a;
      reg_wdata_o <= (a == ADDR_EVENT_MASK) ? (d | 8'h07) : (d & CFG_WRITE_MASK);
      reg_wr_o <= 1'b1;
      @(posedge clk_i);
      reg_wr_o <= 1'b0;
   endtask : wr
   // A lost answer comes back unknown so the caller flags it
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      int n;
      @(posedge clk_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      @(posedge clk_i);
      reg_rd_o <= 1'b0;
      #1;
      for (n = 0; n < 4 && reg_rvalid_i !== 1'b1; n++) begin
         @(posedge clk_i);
         #1;
      end
      d = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 8'hXX;
   endtask : rd
endmodule : eal_host_model

// File: testbench/eal_event_alert_tb_top.sv
// Purpose: Self-checking bench for the event alert block.
// Assumes: Short pulse timer values keep the run brief.
// Notes:   Alert stays low-true except in the polarity case.
`timescale 1ns/1ps
module eal_event_alert_tb_top
   import eal_pkg::*;
;
   localparam int ON_T = 4;
   localparam int PER_T = 10;
   logic clk_i, rst_i, wr, rd, rvalid, pin;
   logic [7:0] addr, wdata, rdata, d;
   logic [4:0] evt;
   int errors, n_checks, on, rises, i;
   eal_event_alert #(.ON_CYC(ON_T), .PERIOD_CYC(PER_T)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
      .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .reg_rvalid_o(rvalid), .evt_audio_serial_port_clk_err_i(evt[4]), .evt_pll_lock_i(evt[3]),
      .evt_mix_sat_i(evt[2]), .evt_voice_activity_detector_up_i(evt[1]),
      .evt_voice_activity_detector_down_i(evt[0]), .alert_pin_o(pin));
   eal_host_model host_u (.clk_i(clk_i), .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata),
      .reg_rd_o(rd), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));
   // Free-running 50 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
         errors++;
      end
   endtask : chk
   task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
      host_u.rd(a, d);
      chk(nm, e, d);
      // A lost read answer has been counted; stop at the report
      if (d === 8'hXX) give_verdict();
   endtask : rdc
   task automatic pulse(input logic [4:0] v);
      @(posedge clk_i);
      evt <= v;
      @(posedge clk_i);
      evt <= 5'h00;
   endtask : pulse
   // Sample after the edge so registered outputs have settled
   task automatic wait_pin(input int n, input logic e, input string nm);
      repeat (n) @(posedge clk_i);
      #1;
      chk(nm, {7'h00, e}, {7'h00, pin});
   endtask : wait_pin
   task automatic watch(input int n);
      logic prev;
      prev = 1'b0;
      on = 0;
      rises = 0;
      repeat (n) begin
         @(posedge clk_i);
         #1;
         if (pin === 1'b0 && !prev) rises++;
         if (pin === 1'b0) on++;
         prev = (pin === 1'b0);
      end
   endtask : watch
   task automatic t_latch();
      for (i = 0; i < 5; i++) begin
         pulse(5'h01 << i);
         rdc(ADDR_EVENT_LATCH, {5'h01 << i, 3'h0}, "latch set");
         rdc(ADDR_EVENT_LATCH, 8'h00, "latch cleared");
         chk("masked pin", 8'h01, {7'h00, pin});
      end
      fork
         host_u.rd(ADDR_EVENT_LATCH, d);
         pulse(5'h08);
      join
      chk("latch during read", 8'h00, d);
      rdc(ADDR_EVENT_LATCH, 8'h40, "latch kept");
   endtask : t_latch
   task automatic t_view();
      host_u.wr(ADDR_EVENT_MASK, 8'h7F);
      host_u.wr(ADDR_ALERT_CONFIG, 8'h04);
      pulse(5'h18);
      rdc(ADDR_EVENT_LATCH, 8'h80, "filtered latch");
      host_u.wr(ADDR_ALERT_CONFIG, 8'h00);
      rdc(ADDR_EVENT_LATCH, 8'h40, "masked bit kept");
      rdc(ADDR_EVENT_LATCH, 8'h00, "latch empty");
   endtask : t_view
   task automatic t_level();
      for (i = 0; i < 5; i++) begin
         host_u.wr(ADDR_EVENT_MASK, ~{5'h01 << i, 3'h0});
         pulse(5'h1F ^ (5'h01 << i));
         rdc(ADDR_EVENT_LATCH, ~{5'h01 << i, 3'h7}, "latch all");
         wait_pin(2, 1'b1, "other events masked");
         pulse(5'h01 << i);
         wait_pin(3, 1'b0, "level pin");
         rdc(ADDR_EVENT_LATCH, {5'h01 << i, 3'h0}, "latch");
         wait_pin(3, 1'b1, "pin released");
      end
      host_u.wr(ADDR_ALERT_CONFIG, 8'h80);
      wait_pin(2, 1'b0, "idle high-true");
      pulse(5'h10);
      wait_pin(3, 1'b1, "active high");
      rdc(ADDR_EVENT_LATCH, 8'h80, "latch");
      wait_pin(3, 1'b0, "released high-true");
   endtask : t_level
   task automatic t_timed();
      host_u.wr(ADDR_ALERT_CONFIG, 8'h40);
      pulse(5'h10);
      watch(30);
      chk("repeat on cycles", 8'(3 * ON_T), 8'(on));
      chk("repeat pulses", 8'h03, 8'(rises));
      rdc(ADDR_EVENT_LATCH, 8'h80, "latch");
      watch(15);
      chk("repeat stopped", 8'h00, 8'(on));
      host_u.wr(ADDR_ALERT_CONFIG, 8'h60);
      repeat (2) begin
         pulse(5'h10);
         watch(20);
         chk("once on cycles", 8'(ON_T), 8'(on));
         chk("once pulses", 8'h01, 8'(rises));
      end
   endtask : t_timed
   task automatic give_verdict();
      $display("checks %0d, errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict
   // Main sequence
   initial begin
      rst_i = 1'b1;
      evt = 5'h00;
      errors = 0;
      n_checks = 0;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      chk("pin after reset", 8'h01, {7'h00, pin});
      rdc(ADDR_ALERT_CONFIG, ALERT_CONFIG_RESET, "config");
      rdc(ADDR_EVENT_MASK, EVENT_MASK_RESET, "mask");
      rdc(ADDR_EVENT_LATCH, EVENT_LATCH_RESET, "latch");
      rdc(8'h34, 8'h00, "unmapped");
      t_latch();
      t_view();
      t_level();
      t_timed();
      give_verdict();
   end
   // Hang guard
   initial begin
      #500_000;
      errors++;
      give_verdict();
   end
endmodule : eal_event_alert_tb_top
